// File: rtl/ptm_top.sv
`timescale 1ns/10ps
// Overview of operation
// - count instruction clock, or pin edges
// - mode from clock-source and gate bits
// - unpaired timers use own prescale, period, run
// - unpaired timer interrupts with own enable, priority
// - pairing bit on lower timer joins pair
// - upper timer holds high half, carry
// - lower control steers pair, upper idle bit
// - pair interrupt uses upper timer bits
// - only timers 0+1 and 2+3 pair
// - 32-bit period is upper:lower period
// - pair prescale from lower, irq as upper
module ptm_top
   import ptm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // count or gate pins and core idle state
   input wire logic [3:0] ext_cnt_i,
   input wire logic idle_i,
   // interrupt
   output logic irq_o,
   output logic [2:0] irq_prio_o
);

   logic [15:0] con_q [PTM_NTIM];
   logic [15:0] cnt_q [PTM_NTIM];
   logic [15:0] cnt_d [PTM_NTIM];
   logic [15:0] per_q [PTM_NTIM];
   logic [3:0] stat_q;
   logic [3:0] mask_q;
   logic [11:0] prio_q;
   logic [3:0] tick;
   logic [3:0] run;
   logic [3:0] evt;
   logic [1:0] paired;
   logic ack_q;
   logic [31:0] dat_q;
   logic [31:0] rdata;
   logic irq_q;
   logic [2:0] prio_out_q;
   logic [2:0] top_prio;
   logic [3:0] pend;
   logic acc;
   logic wr;
   logic blk;
   logic [1:0] tsel;
   logic hit_con;
   logic hit_cnt;
   logic hit_per;
   logic hit_stat;
   logic hit_mask;
   logic hit_prio;
   logic [3:0] clr;

   // bus decode
   assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr = acc & wb_we_i;
   assign tsel = wb_adr_i[5:4];
   assign blk = (wb_adr_i[7:6] == 2'b00);
   assign hit_con = blk & (wb_adr_i[3:0] == PTM_OFF_CON);
   assign hit_cnt = blk & (wb_adr_i[3:0] == PTM_OFF_CNT);
   assign hit_per = blk & (wb_adr_i[3:0] == PTM_OFF_PER);
   assign hit_stat = (wb_adr_i == PTM_OFF_STAT);
   assign hit_mask = (wb_adr_i == PTM_OFF_MASK);
   assign hit_prio = (wb_adr_i == PTM_OFF_PRIO);

   // run gating, per pair of lower and upper timer
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         paired[p] = con_q[2*p][PTM_CON_PAIR];
         run[2*p] = con_q[2*p][PTM_CON_RUN] & ~(idle_i &
            (con_q[2*p][PTM_CON_SIDL] |
             (paired[p] & con_q[2*p+1][PTM_CON_SIDL])));
         run[2*p+1] = con_q[2*p+1][PTM_CON_RUN] & ~paired[p] &
            ~(idle_i & con_q[2*p+1][PTM_CON_SIDL]);
      end
   end

   // one prescaler and tick source per timer
   for (genvar g = 0; g < PTM_NTIM; g++) begin : g_tim
      ptm_presc u_presc (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .run_i(run[g]),
         .mode_i(ptm_mode(con_q[g][PTM_CON_CS], con_q[g][PTM_CON_GATE])),
         .ratio_i(con_q[g][PTM_CON_PS_HI:PTM_CON_PS_LO]),
         .pin_i(ext_cnt_i[g]),
         .tick_o(tick[g])
      );
   end

   // next count and period events
   always_comb begin
      for (int i = 0; i < PTM_NTIM; i++) begin
         cnt_d[i] = cnt_q[i];
         evt[i] = 1'b0;
      end
      for (int p = 0; p < 2; p++) begin
         if (paired[p]) begin
            if (tick[2*p]) begin
               if ({cnt_q[2*p+1], cnt_q[2*p]} ==
                   {per_q[2*p+1], per_q[2*p]}) begin
                  cnt_d[2*p] = 16'h0000;
                  cnt_d[2*p+1] = 16'h0000;
                  evt[2*p+1] = 1'b1;
               end else begin
                  {cnt_d[2*p+1], cnt_d[2*p]} =
                     {cnt_q[2*p+1], cnt_q[2*p]} + 32'h0000_0001;
               end
            end
         end else begin
            for (int k = 0; k < 2; k++) begin
               if (tick[2*p+k]) begin
                  if (cnt_q[2*p+k] == per_q[2*p+k]) begin
                     cnt_d[2*p+k] = 16'h0000;
                     evt[2*p+k] = 1'b1;
                  end else begin
                     cnt_d[2*p+k] = cnt_q[2*p+k] + 16'h0001;
                  end
               end
            end
         end
      end
      for (int i = 0; i < PTM_NTIM; i++) begin
         if (wr && hit_cnt && tsel == i[1:0]) begin
            cnt_d[i] = ptm_merge(cnt_q[i], wb_dat_i[15:0], wb_sel_i[1:0]);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < PTM_NTIM; i++) begin
         if (rst_i) begin
            cnt_q[i] <= PTM_CNT_RST;
         end else begin
            cnt_q[i] <= cnt_d[i];
         end
      end
   end

   // control and period registers
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < PTM_NTIM; i++) begin
         if (rst_i) begin
            con_q[i] <= PTM_CON_RST;
            per_q[i] <= PTM_PER_RST;
         end else if (wr && tsel == i[1:0]) begin
            if (hit_con) begin
               con_q[i] <= ptm_merge(con_q[i], wb_dat_i[15:0],
                  wb_sel_i[1:0]) & (i[0] ? PTM_CON_MASK_C : PTM_CON_MASK_B);
            end
            if (hit_per) begin
               per_q[i] <= ptm_merge(per_q[i], wb_dat_i[15:0], wb_sel_i[1:0]);
            end
         end
      end
   end

   // sticky status, write one to clear; a new event wins over the clear
   assign clr = (wr && hit_stat && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= PTM_STAT_RST;
      end else begin
         stat_q <= (stat_q & ~clr) | evt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= PTM_MASK_RST;
         prio_q <= PTM_PRIO_RST;
      end else begin
         if (wr && hit_mask && wb_sel_i[0]) begin
            mask_q <= wb_dat_i[3:0];
         end
         if (wr && hit_prio) begin
            if (wb_sel_i[0]) begin
               prio_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               prio_q[11:8] <= wb_dat_i[11:8];
            end
         end
      end
   end

   // interrupt level and highest pending priority
   always_comb begin
      pend = stat_q & mask_q;
      // a paired lower timer's own flag may not interrupt
      for (int p = 0; p < 2; p++) begin
         pend[2*p] = pend[2*p] & ~paired[p];
      end
      top_prio = 3'd0;
      for (int i = 0; i < PTM_NTIM; i++) begin
         if (pend[i] && prio_q[3*i +: 3] > top_prio) begin
            top_prio = prio_q[3*i +: 3];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
         prio_out_q <= 3'd0;
      end else begin
         irq_q <= |pend;
         prio_out_q <= top_prio;
      end
   end

   // read mux
   always_comb begin
      rdata = 32'h0000_0000;
      if (hit_con) begin
         rdata[15:0] = con_q[tsel];
      end else if (hit_cnt) begin
         rdata[15:0] = cnt_q[tsel];
      end else if (hit_per) begin
         rdata[15:0] = per_q[tsel];
      end else if (hit_stat) begin
         rdata[3:0] = stat_q;
      end else if (hit_mask) begin
         rdata[3:0] = mask_q;
      end else if (hit_prio) begin
         rdata[11:0] = prio_q;
      end
   end

   // one-cycle acknowledge, also for unmapped addresses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= acc;
         if (acc && !wb_we_i) begin
            dat_q <= rdata;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign irq_o = irq_q;
   assign irq_prio_o = prio_out_q;

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_timer_every_tick: assert property (
      (run[0] && !paired[0] && !con_q[0][PTM_CON_CS] &&
       !con_q[0][PTM_CON_GATE] &&
       con_q[0][PTM_CON_PS_HI:PTM_CON_PS_LO] == 2'd0) |-> tick[0])
      else $error("timer mode with ratio code 0 did not tick");

   a_gate_low_hold: assert property (
      (!con_q[0][PTM_CON_CS] && con_q[0][PTM_CON_GATE] && !ext_cnt_i[0])
      |-> !tick[0])
      else $error("gated timer ticked with gate low");

   a_sync_pin_edge: assert property (
      (con_q[1][PTM_CON_CS] && tick[1]) |->
      (ext_cnt_i[1] && !$past(ext_cnt_i[1])))
      else $error("sync counter ticked without pin rising edge");

   a_count_step: assert property (
      (tick[0] && !paired[0] && cnt_q[0] != per_q[0] && !(wr && hit_cnt))
      |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
      else $error("16-bit count did not step by one");

   a_period_wrap: assert property (
      (tick[0] && !paired[0] && cnt_q[0] == per_q[0] && !(wr && hit_cnt))
      |=> (cnt_q[0] == 16'h0000 && stat_q[0]))
      else $error("count did not wrap and flag at period");

   a_pair_carry: assert property (
      (paired[0] && tick[0] && cnt_q[0] == 16'hFFFF && !(wr && hit_cnt) &&
       {cnt_q[1], cnt_q[0]} != {per_q[1], per_q[0]})
      |=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
      else $error("carry did not reach upper half");

   a_pair_period: assert property (
      (paired[0] && tick[0] && !(wr && hit_cnt) &&
       {cnt_q[1], cnt_q[0]} == {per_q[1], per_q[0]})
      |=> (cnt_q[0] == 16'h0000 && cnt_q[1] == 16'h0000 && stat_q[1]))
      else $error("32-bit period match failed");

   a_pair_lower_quiet: assert property (
      (paired[0] && !stat_q[0]) |=>
      (!stat_q[0] && !$past(run[1])))
      else $error("lower flag or upper run active while paired");

   a_irq_level: assert property (
      ##1 (irq_o == $past(|pend)))
      else $error("interrupt output does not follow pending bits");

   a_run_off_hold: assert property (
      (!con_q[0][PTM_CON_RUN] && !(wr && hit_cnt))
      |=> cnt_q[0] == $past(cnt_q[0]))
      else $error("stopped timer count changed");

   a_gate_high_count: assert property (
      (run[2] && !paired[1] && !con_q[2][PTM_CON_CS] &&
       con_q[2][PTM_CON_GATE] &&
       con_q[2][PTM_CON_PS_HI:PTM_CON_PS_LO] == 2'd0 && ext_cnt_i[2])
      |-> tick[2])
      else $error("gated timer missed a clock with gate high");

   a_idle_stop: assert property (
      (paired[0] && idle_i && con_q[1][PTM_CON_SIDL]) |-> !tick[0])
      else $error("pair counted in idle with upper idle stop set");

   a_prio_own: assert property (
      (pend == 4'h1) |=> irq_prio_o == $past(prio_q[2:0]))
      else $error("single timer priority not reported");

   a_prio_pair: assert property (
      (paired[0] && pend == 4'h2) |=> irq_prio_o == $past(prio_q[5:3]))
      else $error("pair priority not taken from upper timer");

   a_stat_sticky: assert property (
      (stat_q[0] && !(wr && hit_stat && wb_sel_i[0] && wb_dat_i[0]))
      |=> stat_q[0])
      else $error("status bit dropped without a clear");

   a_ack_pulse: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held longer than one cycle");

   a_ack_answer: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");

   c_wrap16: cover property (tick[0] && !paired[0] && cnt_q[0] == per_q[0]);
   c_wrap32: cover property (evt[1] && paired[0]);
   c_irq_rise: cover property (!irq_o ##1 irq_o);
   c_set_clear: cover property (|(evt & clr));

endmodule // ptm_top

// File: rtl/ptm_pkg.sv
package ptm_pkg;

   // timer set layout
   localparam int PTM_NTIM = 4;
   localparam int PTM_CW = 16;
   localparam int PTM_PW = 3;

   // control register field positions
   localparam int PTM_CON_RUN = 15;
   localparam int PTM_CON_SIDL = 13;
   localparam int PTM_CON_GATE = 6;
   localparam int PTM_CON_PS_HI = 5;
   localparam int PTM_CON_PS_LO = 4;
   localparam int PTM_CON_PAIR = 3;
   localparam int PTM_CON_CS = 1;

   // writable bits of a lower-half and an upper-half control register
   localparam logic [15:0] PTM_CON_MASK_B = 16'hA07A;
   localparam logic [15:0] PTM_CON_MASK_C = 16'hA072;

   // reset values
   localparam logic [15:0] PTM_CON_RST = 16'h0000;
   localparam logic [15:0] PTM_CNT_RST = 16'h0000;
   localparam logic [15:0] PTM_PER_RST = 16'hFFFF;
   localparam logic [3:0] PTM_STAT_RST = 4'h0;
   localparam logic [3:0] PTM_MASK_RST = 4'h0;
   localparam logic [11:0] PTM_PRIO_RST = 12'h000;

   // byte offsets: per-timer block at timer index * 0x10
   localparam logic [3:0] PTM_OFF_CON = 4'h0;
   localparam logic [3:0] PTM_OFF_CNT = 4'h4;
   localparam logic [3:0] PTM_OFF_PER = 4'h8;
   localparam logic [7:0] PTM_OFF_STAT = 8'h40;
   localparam logic [7:0] PTM_OFF_MASK = 8'h44;
   localparam logic [7:0] PTM_OFF_PRIO = 8'h48;

   // prescaler terminal counts for ratio codes 0..3
   localparam logic [7:0] PTM_DIV0 = 8'h00;
   localparam logic [7:0] PTM_DIV1 = 8'h07;
   localparam logic [7:0] PTM_DIV2 = 8'h3F;
   localparam logic [7:0] PTM_DIV3 = 8'hFF;

   typedef enum logic [1:0] {
      PTM_MODE_TIMER,
      PTM_MODE_GATED,
      PTM_MODE_SYNC
   } ptm_mode_t;

   function automatic ptm_mode_t ptm_mode(input logic cs, input logic gate);
      if (cs) begin
         return PTM_MODE_SYNC;
      end
      return gate ? PTM_MODE_GATED : PTM_MODE_TIMER;
   endfunction

   function automatic logic [7:0] ptm_div(input logic [1:0] ratio);
      case (ratio)
         2'd0: return PTM_DIV0;
         2'd1: return PTM_DIV1;
         2'd2: return PTM_DIV2;
         default: return PTM_DIV3;
      endcase
   endfunction

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] ptm_merge(input logic [15:0] old,
                                             input logic [15:0] wdat,
                                             input logic [1:0] sel);
      return {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
   endfunction

endpackage

// File: rtl/ptm_presc.sv
`timescale 1ns/10ps
module ptm_presc
   import ptm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire ptm_mode_t mode_i,
   input wire logic [1:0] ratio_i,
   // external count or gate pin
   input wire logic pin_i,
   // one-cycle count tick
   output logic tick_o
);

   logic pin_q;
   logic [7:0] ps_q;
   logic base;
   logic last;

   // base event: instruction clock, gated clock or pin rising edge
   always_comb begin
      case (mode_i)
         PTM_MODE_TIMER: base = 1'b1;
         PTM_MODE_GATED: base = pin_i;
         PTM_MODE_SYNC: base = pin_i & ~pin_q;
         default: base = 1'b0;
      endcase
   end

   // a ratio lowered while running must not wait for the divider to wrap
   assign last = (ps_q >= ptm_div(ratio_i));
   assign tick_o = run_i & base & last;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         ps_q <= 8'h00;
      end else if (base) begin
         ps_q <= last ? 8'h00 : ps_q + 8'h01;
      end
   end

endmodule // ptm_presc

// File: tb/ptm_pin_model.sv
`timescale 1ns/10ps
module ptm_pin_model (
   // clock
   input wire logic clk_i,
   // count or gate pins
   output logic [3:0] pin_o
);
   initial pin_o = 4'h0;

   // one-cycle high pulses, always one low cycle between them
   task automatic edges(input int t, input int n);
      repeat (n) begin
         @(posedge clk_i);
         pin_o[t] <= 1'b1;
         @(posedge clk_i);
         pin_o[t] <= 1'b0;
      end
   endtask

   // gate held high for exactly n sampling edges
   task automatic level(input int t, input int n);
      @(posedge clk_i);
      pin_o[t] <= 1'b1;
      repeat (n) @(posedge clk_i);
      pin_o[t] <= 1'b0;
   endtask
endmodule // ptm_pin_model

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import ptm_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, idle_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, ext_cnt_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [2:0] irq_prio_o;
   logic [23:0] exp_q[$];
   logic [23:0] mon_e;
   logic [15:0] seed;
   int failures = 0;
   int num_checks = 0;

   always #50 clk_i = ~clk_i;

   ptm_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o), .ext_cnt_i(ext_cnt_i), .idle_i(idle_i),
      .irq_o(irq_o), .irq_prio_o(irq_prio_o));

   ptm_pin_model pin_u (.clk_i(clk_i), .pin_o(ext_cnt_i));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task complete_run;
      $display("checks %0d errors %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // classic cycle: hold everything until ack is sampled high
   task bus(input logic [7:0] a, input logic w, input logic [15:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'h3;
      wb_dat_i <= {16'h0000, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         failures++;
         complete_run();
      end else begin
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask

   task wr(input logic [7:0] a, input logic [15:0] d);
      bus(a, 1'b1, d);
   endtask

   task rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back({a, e});
      bus(a, 1'b0, 16'h0000);
   endtask

   task irq_chk(input logic e, input logic [2:0] p);
      repeat (2) @(posedge clk_i);
      chk("irq", 32'(e), 32'(irq_o));
      chk("prio", 32'(p), 32'(irq_prio_o));
   endtask

   // read data is compared at the edge where ack is seen
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         mon_e = exp_q.pop_front();
         chk($sformatf("reg %h", mon_e[23:16]), {16'h0000, mon_e[15:0]},
            wb_dat_o);
      end
   end

   initial begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      idle_i = 1'b0;
      seed = 16'h0003;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h00, 16'h0000);
      rd(8'h08, 16'hFFFF);
      rd(8'h40, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr(8'(i * 16 + 8), seed);
         rd(8'(i * 16 + 8), seed);
      end
      wr(8'h4C, 16'h00FF);
      rd(8'h4C, 16'h0000);
      // timer mode wrap raises own interrupt with own priority
      wr(8'h48, 16'h0032);
      wr(8'h08, 16'h0002);
      wr(8'h44, 16'h0001);
      wr(8'h00, 16'h8000);
      repeat (10) @(posedge clk_i);
      rd(8'h40, 16'h0001);
      irq_chk(1'b1, 3'h2);
      wr(8'h44, 16'h0000);
      irq_chk(1'b0, 3'h0);
      wr(8'h00, 16'h0000);
      wr(8'h40, 16'h000F);
      rd(8'h40, 16'h0000);
      // edge counting, gate ignored, pair bit absent on upper timer
      wr(8'h18, 16'h0003);
      wr(8'h10, 16'h804A);
      rd(8'h10, 16'h8042);
      rd(8'h14, 16'h0000);
      pin_u.edges(1, 2);
      rd(8'h14, 16'h0002);
      pin_u.edges(1, 2);
      rd(8'h14, 16'h0000);
      rd(8'h40, 16'h0002);
      // gated accumulation
      wr(8'h28, 16'h00FF);
      wr(8'h20, 16'h8040);
      pin_u.level(2, 5);
      rd(8'h24, 16'h0005);
      // prescale 1:8 on edges
      wr(8'h38, 16'h00FF);
      wr(8'h30, 16'h801A);
      rd(8'h30, 16'h8012);
      pin_u.edges(3, 16);
      rd(8'h34, 16'h0002);
      // 32-bit pair: carry, joint period, upper-half interrupt
      wr(8'h40, 16'h000F);
      wr(8'h14, 16'h0000);
      wr(8'h04, 16'hFFFE);
      wr(8'h08, 16'h0002);
      wr(8'h18, 16'h0001);
      wr(8'h44, 16'h0003);
      wr(8'h00, 16'h8048);
      pin_u.level(0, 3);
      rd(8'h04, 16'h0001);
      rd(8'h14, 16'h0001);
      rd(8'h40, 16'h0000);
      pin_u.level(0, 2);
      rd(8'h04, 16'h0000);
      rd(8'h14, 16'h0000);
      rd(8'h40, 16'h0002);
      irq_chk(1'b1, 3'h6);
      // upper idle stop still holds the pair, its run bit does not
      wr(8'h10, 16'h2000);
      idle_i <= 1'b1;
      pin_u.level(0, 3);
      rd(8'h04, 16'h0000);
      idle_i <= 1'b0;
      pin_u.level(0, 3);
      rd(8'h04, 16'h0003);
      rd(8'h14, 16'h0000);
      repeat (4) @(posedge clk_i);
      complete_run();
   end
endmodule // tb_top
